/* inc/emb_pkg.sv */
// Purpose: Shared constants and types for the entry mode and booster soft-start command block.
// Assumes: 25 MHz pclk, command bytes arriving over a clocked serial link.
// Notes: Constants and types only; the logic lives in the modules that import this package.

package emb_pkg;

  localparam logic [7:0] CMD_ENTRY_MODE = 8'h11;
  localparam logic [7:0] CMD_BOOST_SOFT = 8'h0c;

  localparam logic [2:0] ENTRY_POR = 3'h3;
  localparam logic [7:0] PH1_POR = 8'h8b;
  localparam logic [7:0] PH2_POR = 8'h9c;
  localparam logic [7:0] PH3_POR = 8'h96;
  localparam logic [7:0] DUR_POR = 8'h0f;

  localparam int STEP_X_BIT = 0;
  localparam int STEP_Y_BIT = 1;
  localparam int AXIS_BIT = 2;
  localparam int STR_MSB = 6;
  localparam int STR_LSB = 4;
  localparam int OFF_MSB = 3;
  localparam int OFF_LSB = 0;
  localparam logic [3:0] OFF_MIN_CODE = 4'h4;
  localparam int DUR_PH1_LSB = 0;
  localparam int DUR_PH2_LSB = 2;
  localparam int DUR_PH3_LSB = 4;
  localparam logic [1:0] BOOST_LAST_IDX = 2'h3;

  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_BOOST = 12'h008;
  localparam logic [11:0] REG_ADDR = 12'h00c;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_RAMWR_BIT = 1;
  localparam int STAT_BUSY_BIT = 4;
  localparam int STAT_PHASE_LSB = 5;
  localparam int ADDR_Y_LSB = 16;

  localparam int ADDR_X_W = 8;
  localparam int ADDR_Y_W = 9;
  localparam int LINK_BITS = 8;

  localparam int CLK_HZ = 25_000_000;
  localparam int PHASE_STEP_MS = 10;
  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] PHASE_STEP_CYC = CNT_W'(CLK_HZ / 1000 * PHASE_STEP_MS);

  typedef struct packed {
    logic is_data;
    logic [7:0] value;
  } emb_byte_t;

  typedef struct packed {
    logic [7:0] dur;
    logic [7:0] ph3;
    logic [7:0] ph2;
    logic [7:0] ph1;
  } emb_boost_t;

  typedef enum {DEC_IDLE, DEC_ENTRY, DEC_BOOST} emb_dec_t;
  typedef enum {BS_IDLE, BS_PH1, BS_PH2, BS_PH3} emb_bs_t;

endpackage

/* src/emb_link_rx.sv */
// Purpose: Deserialises command and data bytes from the host serial link.
// Assumes: Link pins are asynchronous to pclk; data sampled on the link clock rising edge, MSB first.
// Notes: Chip select high clears a partial byte.
`timescale 1ns/100ps
`default_nettype none

module emb_link_rx
  import emb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic link_sclk,
  input wire logic link_csn,
  input wire logic link_dc,
  input wire logic link_sdin,
  output emb_byte_t rx_byte,
  output logic rx_valid
);

  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic sclk_d_r;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [2:0] bits_r;
  logic [2:0] bits_nxt;
  emb_byte_t byte_r;
  emb_byte_t byte_nxt;
  logic valid_r;
  logic valid_nxt;
  logic rise;

  // Two-stage synchroniser for sclk, csn, dc, sdin.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= 4'hf;
      sync_r <= 4'hf;
      sclk_d_r <= 1'b1;
    end
    else
    begin
      meta_r <= {link_sclk, link_csn, link_dc, link_sdin};
      sync_r <= meta_r;
      sclk_d_r <= sync_r[3];
    end
  end

  assign rise = sync_r[3] && !sclk_d_r && !sync_r[2];

  always_comb
  begin
    shift_nxt = shift_r;
    bits_nxt = bits_r;
    byte_nxt = byte_r;
    valid_nxt = 1'b0;
    if (sync_r[2])
    begin
      bits_nxt = 3'h0;
    end
    else if (rise)
    begin
      shift_nxt = {shift_r[6:0], sync_r[0]};
      bits_nxt = 3'(bits_r + 3'h1);
      if (bits_r == 3'(LINK_BITS - 1))
      begin
        byte_nxt.value = {shift_r[6:0], sync_r[0]};
        byte_nxt.is_data = sync_r[1];
        valid_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_r <= 8'h00;
      bits_r <= 3'h0;
      byte_r <= '0;
      valid_r <= 1'b0;
    end
    else
    begin
      shift_r <= shift_nxt;
      bits_r <= bits_nxt;
      byte_r <= byte_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign rx_byte = byte_r;
  assign rx_valid = valid_r;

endmodule
`default_nettype wire

/* src/emb_top.sv */
// Purpose: Decodes entry mode and booster soft-start commands, stores them, steps the RAM
//   address counter and runs the three-phase soft-start sequence; APB gives software access.
// Assumes: 25 MHz pclk; host link pins asynchronous to pclk.
// Notes: Phase length is a parameter so simulation can shorten it.
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module emb_top
  import emb_pkg::*;
#(
  parameter logic [CNT_W-1:0] PHASE_STEP_CYC_P = PHASE_STEP_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_sclk,
  input wire logic link_csn,
  input wire logic link_dc,
  input wire logic link_sdin,
  output logic [1:0] address_step_direction,
  output logic address_update_axis,
  output logic [ADDR_X_W-1:0] addr_x,
  output logic [ADDR_Y_W-1:0] addr_y,
  output logic boost_active,
  output logic [1:0] boost_phase,
  output logic [2:0] drive_strength,
  output logic [3:0] gate_drive_switch_min_off
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic [CNT_W-1:0] dur_last(input logic [1:0] code, input logic [CNT_W-1:0] unit);
    logic [CNT_W+2:0] prod;
    prod = unit * ({1'b0, code} + 3'h1);
    dur_last = CNT_W'(prod - 1'b1);
  endfunction

  function automatic logic [3:0] off_code(input logic [7:0] ph);
    off_code = (ph[OFF_MSB:OFF_LSB] < OFF_MIN_CODE) ? OFF_MIN_CODE : ph[OFF_MSB:OFF_LSB];
  endfunction

  function automatic logic reg_hit(input logic [11:0] a);
    reg_hit = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_BOOST) || (a == REG_ADDR);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Link receiver.

  emb_byte_t rx_byte;
  logic rx_valid;

  emb_link_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .link_sclk(link_sclk),
    .link_csn(link_csn),
    .link_dc(link_dc),
    .link_sdin(link_sdin),
    .rx_byte(rx_byte),
    .rx_valid(rx_valid)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Command decoder and parameter store.

  emb_dec_t dec_r;
  emb_dec_t dec_nxt;
  logic [1:0] idx_r;
  logic [1:0] idx_nxt;
  logic [2:0] entry_r;
  logic [2:0] entry_nxt;
  emb_boost_t boost_r;
  emb_boost_t boost_nxt;
  logic cmd_start_r;
  logic cmd_start_nxt;

  always_comb
  begin
    dec_nxt = dec_r;
    idx_nxt = idx_r;
    entry_nxt = entry_r;
    boost_nxt = boost_r;
    cmd_start_nxt = 1'b0;
    if (rx_valid && !rx_byte.is_data)
    begin
      idx_nxt = 2'h0;
      case (rx_byte.value)
        CMD_ENTRY_MODE: dec_nxt = DEC_ENTRY;
        CMD_BOOST_SOFT: dec_nxt = DEC_BOOST;
        default: dec_nxt = DEC_IDLE;
      endcase
    end
    else if (rx_valid)
    begin
      case (dec_r)
        DEC_ENTRY:
        begin
          entry_nxt = rx_byte.value[2:0];
          dec_nxt = DEC_IDLE;
        end
        DEC_BOOST:
        begin
          // Bytes are kept whole; the host is expected to send bit seven set on phase bytes.
          case (idx_r)
            2'h0: boost_nxt.ph1 = rx_byte.value;
            2'h1: boost_nxt.ph2 = rx_byte.value;
            2'h2: boost_nxt.ph3 = rx_byte.value;
            default: boost_nxt.dur = rx_byte.value;
          endcase
          idx_nxt = 2'(idx_r + 2'h1);
          if (idx_r == BOOST_LAST_IDX)
          begin
            dec_nxt = DEC_IDLE;
            cmd_start_nxt = 1'b1;
          end
        end
        default: dec_nxt = DEC_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dec_r <= DEC_IDLE;
      idx_r <= 2'h0;
      entry_r <= ENTRY_POR;
      boost_r <= {DUR_POR, PH3_POR, PH2_POR, PH1_POR};
      cmd_start_r <= 1'b0;
    end
    else
    begin
      dec_r <= dec_nxt;
      idx_r <= idx_nxt;
      entry_r <= entry_nxt;
      boost_r <= boost_nxt;
      cmd_start_r <= cmd_start_nxt;
    end
  end

  assign address_step_direction = entry_r[STEP_Y_BIT:STEP_X_BIT];
  assign address_update_axis = entry_r[AXIS_BIT];

  ////////////////////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, pready and prdata registered.

  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic sw_start_r;
  logic sw_start_nxt;
  logic ram_wr_r;
  logic ram_wr_nxt;
  logic addr_set_r;
  logic addr_set_nxt;
  logic [31:0] addr_wdata_r;
  logic [31:0] addr_wdata_nxt;
  logic apb_req;
  logic apb_done;

  assign apb_req = psel && penable && !pready_r;
  assign apb_done = psel && penable && pready_r;

  always_comb
  begin
    pready_nxt = apb_req;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0;
    sw_start_nxt = 1'b0;
    ram_wr_nxt = 1'b0;
    addr_set_nxt = 1'b0;
    addr_wdata_nxt = addr_wdata_r;
    if (apb_req)
    begin
      pslverr_nxt = !reg_hit(paddr) || (pwrite && (paddr == REG_STATUS || paddr == REG_BOOST));
      if (!pwrite)
      begin
        case (paddr)
          REG_STATUS:
          begin
            prdata_nxt[2:0] = entry_r;
            prdata_nxt[STAT_BUSY_BIT] = boost_active;
            prdata_nxt[STAT_PHASE_LSB +: 2] = boost_phase;
          end
          REG_BOOST: prdata_nxt = boost_r;
          REG_ADDR:
          begin
            prdata_nxt[ADDR_X_W-1:0] = addr_x;
            prdata_nxt[ADDR_Y_LSB +: ADDR_Y_W] = addr_y;
          end
          default: prdata_nxt = 32'h0;
        endcase
      end
    end
    if (apb_done && pwrite)
    begin
      if (paddr == REG_CTRL)
      begin
        sw_start_nxt = pwdata[CTRL_START_BIT];
        ram_wr_nxt = pwdata[CTRL_RAMWR_BIT];
      end
      if (paddr == REG_ADDR)
      begin
        addr_set_nxt = 1'b1;
        addr_wdata_nxt = pwdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
      sw_start_r <= 1'b0;
      ram_wr_r <= 1'b0;
      addr_set_r <= 1'b0;
      addr_wdata_r <= 32'h0;
    end
    else
    begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      sw_start_r <= sw_start_nxt;
      ram_wr_r <= ram_wr_nxt;
      addr_set_r <= addr_set_nxt;
      addr_wdata_r <= addr_wdata_nxt;
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // RAM address counter.

  logic [ADDR_X_W-1:0] ax_r;
  logic [ADDR_X_W-1:0] ax_nxt;
  logic [ADDR_Y_W-1:0] ay_r;
  logic [ADDR_Y_W-1:0] ay_nxt;

  always_comb
  begin
    ax_nxt = ax_r;
    ay_nxt = ay_r;
    if (addr_set_r)
    begin
      ax_nxt = addr_wdata_r[ADDR_X_W-1:0];
      ay_nxt = addr_wdata_r[ADDR_Y_LSB +: ADDR_Y_W];
    end
    else if (ram_wr_r)
    begin
      if (!entry_r[AXIS_BIT])
      begin
        ax_nxt = entry_r[STEP_X_BIT] ? ADDR_X_W'(ax_r + 1'b1) : ADDR_X_W'(ax_r - 1'b1);
      end
      else
      begin
        ay_nxt = entry_r[STEP_Y_BIT] ? ADDR_Y_W'(ay_r + 1'b1) : ADDR_Y_W'(ay_r - 1'b1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ax_r <= '0;
      ay_r <= '0;
    end
    else
    begin
      ax_r <= ax_nxt;
      ay_r <= ay_nxt;
    end
  end

  assign addr_x = ax_r;
  assign addr_y = ay_r;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Soft-start sequencer.

  emb_bs_t bs_r;
  emb_bs_t bs_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [2:0] str_r;
  logic [2:0] str_nxt;
  logic [3:0] off_r;
  logic [3:0] off_nxt;
  logic [1:0] ph_r;
  logic [1:0] ph_nxt;
  logic active_r;
  logic active_nxt;

  always_comb
  begin
    bs_nxt = bs_r;
    cnt_nxt = cnt_r;
    str_nxt = str_r;
    off_nxt = off_r;
    ph_nxt = ph_r;
    if (cmd_start_r || sw_start_r)
    begin
      bs_nxt = BS_PH1;
      ph_nxt = 2'h1;
      cnt_nxt = dur_last(boost_r.dur[DUR_PH1_LSB +: 2], PHASE_STEP_CYC_P);
      str_nxt = boost_r.ph1[STR_MSB:STR_LSB];
      off_nxt = off_code(boost_r.ph1);
    end
    else if (cnt_r != '0)
    begin
      cnt_nxt = CNT_W'(cnt_r - 1'b1);
    end
    else
    begin
      case (bs_r)
        BS_PH1:
        begin
          bs_nxt = BS_PH2;
          ph_nxt = 2'h2;
          cnt_nxt = dur_last(boost_r.dur[DUR_PH2_LSB +: 2], PHASE_STEP_CYC_P);
          str_nxt = boost_r.ph2[STR_MSB:STR_LSB];
          off_nxt = off_code(boost_r.ph2);
        end
        BS_PH2:
        begin
          bs_nxt = BS_PH3;
          ph_nxt = 2'h3;
          cnt_nxt = dur_last(boost_r.dur[DUR_PH3_LSB +: 2], PHASE_STEP_CYC_P);
          str_nxt = boost_r.ph3[STR_MSB:STR_LSB];
          off_nxt = off_code(boost_r.ph3);
        end
        BS_PH3:
        begin
          bs_nxt = BS_IDLE;
          ph_nxt = 2'h0;
          str_nxt = 3'h0;
          off_nxt = 4'h0;
        end
        default: bs_nxt = BS_IDLE;
      endcase
    end
    // The active flag is kept in its own flop so the output is not a decode.
    active_nxt = (ph_nxt != 2'h0);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bs_r <= BS_IDLE;
      cnt_r <= '0;
      str_r <= 3'h0;
      off_r <= 4'h0;
      ph_r <= 2'h0;
      active_r <= 1'b0;
    end
    else
    begin
      bs_r <= bs_nxt;
      cnt_r <= cnt_nxt;
      str_r <= str_nxt;
      off_r <= off_nxt;
      ph_r <= ph_nxt;
      active_r <= active_nxt;
    end
  end

  assign boost_phase = ph_r;
  assign boost_active = active_r;
  assign drive_strength = str_r;
  assign gate_drive_switch_min_off = off_r;

endmodule
`default_nettype wire

/* verif/emb_top_properties.sv */
// Purpose: Concurrent checks on the entry mode and soft-start outputs of emb_top.
// Assumes: Single pclk domain, presetn asynchronous and active low.
// Notes: Attached to every emb_top by the bind at the foot of this file.
`timescale 1ns/100ps
`default_nettype none

module emb_chk
  import emb_pkg::*;
#(
  parameter logic [CNT_W-1:0] PHASE_STEP_CYC_P = PHASE_STEP_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [1:0] address_step_direction,
  input wire logic address_update_axis,
  input wire logic [ADDR_X_W-1:0] addr_x,
  input wire logic [ADDR_Y_W-1:0] addr_y,
  input wire logic boost_active,
  input wire logic [1:0] boost_phase,
  input wire logic [2:0] drive_strength,
  input wire logic [3:0] gate_drive_switch_min_off
);
  // Cycles spent in the current phase; cleared on every change and while idle.
  logic [31:0] len_r, len_nxt;
  logic [1:0] ph_r, ph_nxt;

  always_comb
  begin
    ph_nxt = boost_phase;
    len_nxt = (boost_phase != ph_r || boost_phase == 2'h0) ? 32'h0 : len_r + 32'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph_r <= 2'h0;
      len_r <= 32'h0;
    end
    else
    begin
      ph_r <= ph_nxt;
      len_r <= len_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence ramwr_s;
    psel && penable && pready && pwrite && paddr == REG_CTRL && pwdata[CTRL_RAMWR_BIT];
  endsequence

  por_mode_a: assert property ($rose(presetn) |-> address_step_direction == 2'h3 && !address_update_axis)
    else $error("entry mode not at reset value");
  idle_drive_a: assert property (boost_phase == 2'h0 |-> drive_strength == 3'h0 && gate_drive_switch_min_off == 4'h0)
    else $error("drive outputs active while idle");
  active_flag_a: assert property (boost_active == (boost_phase != 2'h0))
    else $error("active flag disagrees with phase");
  min_off_a: assert property (boost_phase != 2'h0 |-> gate_drive_switch_min_off >= OFF_MIN_CODE)
    else $error("min off time below usable code");
  phase_start_a: assert property ($past(boost_phase) == 2'h0 && boost_phase != 2'h0 |-> boost_phase == 2'h1)
    else $error("sequence did not start in phase one");
  phase_next_a: assert property ($changed(boost_phase) |-> boost_phase == $past(boost_phase) + 2'h1 || boost_phase == 2'h1)
    else $error("phase order broken");
  phase_len_a: assert property (boost_phase != 2'h0 |-> len_r < 4 * PHASE_STEP_CYC_P)
    else $error("phase longer than longest duration");
  drive_hold_a: assert property ($stable(boost_phase) && boost_phase != 2'h0 |-> $stable(drive_strength))
    else $error("drive strength changed within a phase");
  step_x_a: assert property (ramwr_s |-> ##3 (address_update_axis ? addr_x == $past(addr_x, 3) :
    addr_x == $past(addr_x, 3) + (address_step_direction[0] ? 8'h01 : 8'hff)))
    else $error("x counter step wrong");
  step_y_a: assert property (ramwr_s |-> ##3 (!address_update_axis ? addr_y == $past(addr_y, 3) :
    addr_y == $past(addr_y, 3) + (address_step_direction[1] ? 9'h001 : 9'h1ff)))
    else $error("y counter step wrong");
endmodule

bind emb_top emb_chk #(.PHASE_STEP_CYC_P(PHASE_STEP_CYC_P)) i_emb_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .address_step_direction(address_step_direction), .address_update_axis(address_update_axis),
  .addr_x(addr_x), .addr_y(addr_y), .boost_active(boost_active), .boost_phase(boost_phase),
  .drive_strength(drive_strength), .gate_drive_switch_min_off(gate_drive_switch_min_off));

`default_nettype wire

/* verif/emb_host.sv */
// Purpose: Host side of the serial command link.
// Assumes: Link clock period of 8 pclk cycles, data changed while the link clock is low.
// Notes: The link clock stands low outside bytes and data shows the inverse of its last bit.
`timescale 1ns/100ps
`default_nettype none

module emb_host
(
  input wire logic pclk,
  output logic link_sclk,
  output logic link_csn,
  output logic link_dc,
  output logic link_sdin
);
  initial
  begin
    link_sclk = 1'b0;
    link_csn = 1'b1;
    link_dc = 1'b0;
    link_sdin = 1'b0;
  end

  // One byte, most significant bit first, with dc held for the whole byte.
  task automatic send(input logic dc, input logic [7:0] v);
    @(posedge pclk);
    link_csn <= 1'b0;
    link_dc <= dc;
    for (int i = 7; i >= 0; i--)
    begin
      link_sdin <= v[i];
      repeat (4) @(posedge pclk);
      link_sclk <= 1'b1;
      repeat (4) @(posedge pclk);
      link_sclk <= 1'b0;
    end
    repeat (4) @(posedge pclk);
    link_csn <= 1'b1;
    link_sdin <= ~v[0];
  endtask
endmodule

`default_nettype wire

/* verif/emb_top_tb.sv */
// Purpose: Self-checking bench for emb_top over APB and the serial link.
// Assumes: Phase step shortened to 20 cycles.
// Notes: Expected values come from the package constants and the sent bytes.
`timescale 1ns/100ps
`default_nettype none

module emb_top_tb;
  import emb_pkg::*;
  localparam logic [CNT_W-1:0] STEP = 24'h000014;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic link_sclk, link_csn, link_dc, link_sdin, address_update_axis, boost_active;
  logic [1:0] address_step_direction, boost_phase;
  logic [ADDR_X_W-1:0] addr_x;
  logic [ADDR_Y_W-1:0] addr_y;
  logic [2:0] drive_strength;
  logic [3:0] gate_drive_switch_min_off;
  int err_total = 0;
  int compares = 0;

  emb_top #(.PHASE_STEP_CYC_P(STEP)) i_emb_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_sclk(link_sclk), .link_csn(link_csn),
    .link_dc(link_dc), .link_sdin(link_sdin), .address_step_direction(address_step_direction),
    .address_update_axis(address_update_axis), .addr_x(addr_x), .addr_y(addr_y),
    .boost_active(boost_active), .boost_phase(boost_phase), .drive_strength(drive_strength),
    .gate_drive_switch_min_off(gate_drive_switch_min_off));
  emb_host i_emb_host (.pclk(pclk), .link_sclk(link_sclk), .link_csn(link_csn), .link_dc(link_dc),
    .link_sdin(link_sdin));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    if (n >= 50)
    begin
      err_total++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Follows one soft-start run and checks each phase's outputs and length.
  task automatic watch(input emb_boost_t b);
    logic [7:0] ph;
    int n;
    n = 0;
    while (boost_phase !== 2'h1 && n < 3000)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    for (int p = 1; p <= 3; p++)
    begin
      ph = (p == 1) ? b.ph1 : (p == 2) ? b.ph2 : b.ph3;
      check(boost_phase, p);
      check(boost_active, 1);
      check(drive_strength, ph[6:4]);
      check(gate_drive_switch_min_off, ph[3:0] < 4'h4 ? 4'h4 : ph[3:0]);
      n = 0;
      while (boost_phase === p[1:0] && n < 1000)
      begin
        @(posedge pclk);
        #1;
        n++;
      end
      check(n, (b.dur[2*(p-1) +: 2] + 1) * STEP);
    end
    check({boost_active, drive_strength, gate_drive_switch_min_off}, 0);
  endtask

  initial
  begin
    logic [31:0] q;
    logic e;
    logic [7:0] ex;
    logic [8:0] ey;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({address_update_axis, address_step_direction}, ENTRY_POR);
    apb(1'b1, REG_BOOST, 32'h0, q, e);
    check(e, 1);
    apb(1'b0, REG_BOOST, 32'h0, q, e);
    check(q, {DUR_POR, PH3_POR, PH2_POR, PH1_POR});
    apb(1'b0, 12'h010, 32'h0, q, e);
    check(e, 1);
    check(q, 0);
    fork
      apb(1'b1, REG_CTRL, 32'h1, q, e);
      watch({DUR_POR, PH3_POR, PH2_POR, PH1_POR});
    join
    $display("reset values and default soft-start done");
    for (int m = 0; m < 8; m++)
    begin
      i_emb_host.send(1'b0, CMD_ENTRY_MODE);
      i_emb_host.send(1'b1, {5'h1f, m[2:0]});
      repeat (10) @(posedge pclk);
      check({address_update_axis, address_step_direction}, m);
      apb(1'b1, REG_ADDR, 32'h0080_0040, q, e);
      apb(1'b1, REG_CTRL, 32'h2, q, e);
      repeat (4) @(posedge pclk);
      apb(1'b0, REG_ADDR, 32'h0, q, e);
      ex = m[2] ? 8'h40 : (m[0] ? 8'h41 : 8'h3f);
      ey = !m[2] ? 9'h080 : (m[1] ? 9'h081 : 9'h07f);
      check(q, {7'h00, ey, 8'h00, ex});
    end
    i_emb_host.send(1'b0, 8'h18);
    i_emb_host.send(1'b1, 8'h02);
    repeat (10) @(posedge pclk);
    apb(1'b0, REG_STATUS, 32'h0, q, e);
    check(q[2:0], 3'h7);
    $display("entry modes done");
    fork
      begin
        // Phase bytes carry bit seven set, the duration byte its top bits clear.
        i_emb_host.send(1'b0, CMD_BOOST_SOFT);
        i_emb_host.send(1'b1, 8'hf3);
        i_emb_host.send(1'b1, 8'h85);
        i_emb_host.send(1'b1, 8'ha9);
        i_emb_host.send(1'b1, 8'h24);
      end
      watch(32'h24a985f3);
    join
    apb(1'b0, REG_BOOST, 32'h0, q, e);
    check(q, 32'h24a985f3);
    $display("booster command done");
    conclude();
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    err_total++;
    conclude();
  end
endmodule

`default_nettype wire
